// ---- eau_add16.sv ----
// eau_add16.sv: 16-bit address adder, wraps silently
// assumes operands come from logic on the same clock
`timescale 1ns/1ns
module eau_add16 (
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  output logic      [15:0] sum_o
);
  // carry out dropped on purpose: address space wraps
  assign sum_o = a_i + b_i;
endmodule : eau_add16

// ---- eau_bus_mem.sv ----
// eau_bus_mem.sv: model of the on-chip memory on the indirect read bus
// assumes the unit owns all bus timing; there are no wait states here
`timescale 1ns/1ns
module eau_bus_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        bus_req_i,
  input  wire logic [15:0] bus_addr_i,
  output logic      [15:0] rdata_o
);
  // ------------------------------------------------------------------
  // contents and read port
  // ------------------------------------------------------------------
  logic [15:0] last_q = 16'h0000;

  // word content derived from the even address, so odd reads show up
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[7:0] ^ 8'ha5, a[7:1], 1'b1};
  endfunction : mem_word

  // data held for every state of the cycle; once released the
  // bus shows the inverse so a late sample never looks right
  assign rdata_o = bus_req_i ? mem_word(bus_addr_i & 16'hfffe)
                             : ~last_q;

  always_ff @(posedge clk_sys_i) begin
    if (bus_req_i) begin
      last_q <= rdata_o;
    end
  end
endmodule : eau_bus_mem

// ---- eau_core.sv ----
// eau_core.sv: operand and branch target address generation
// assumes the decoder holds req_i stable while req_valid_i is high, and
// clk_sys_i is whichever operating clock (system or sub) is selected
//
// Function
// - displacement mode address_add_small 16-bit second word to the selected register
// - displacement mode only for moves; word move needs even address
// - post-increment uses register as address, then address_add_small 1 or 2
// - post-increment only for loading moves; word needs even register
// - pre-decrement subtracts 1 or 2 first, uses and keeps result
// - pre-decrement only for storing moves; word needs even register
// - short absolute forces upper address byte to all ones
// - short absolute for byte moves, bit ops; long for moves, jumps
// - 8-bit immediate from byte 2, 16-bit from bytes 3-4, word moves
// - small address add and subtract carry implicit 1 or 2
// - bit number may come from 3-bit field in byte 2 or 4
// - branches add sign-extended byte 2 displacement to program counter
// - relative reach -126 to +128 bytes; software gives even offsets
// - memory indirect reads word at zero-extended byte 2 address
// - odd branch target or word operand address has bit 0 cleared
// - alu uses register direct; some byte ops also take immediates
// - data transfers take all modes but relative and memory indirect
// - bit ops use direct, indirect or short absolute; separate bit source
// - sequencing runs on the currently selected operating clock
// - state is one clock period; bus cycle lasts two or three states
// - register indirect uses the register contents as address
// - register direct holds the operand itself, not an address
`timescale 1ns/1ns
module eau_core (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              req_valid_i,
  input  wire eau_pkg::eau_req_s req_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output eau_pkg::eau_rsp_s      rsp_o,
  output logic                   bus_req_o,
  output logic                   bus_word_o,
  output logic [15:0]            bus_addr_o,
  input  wire logic [15:0]       bus_rdata_i
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic is_move(input eau_pkg::eau_class_e c);
    is_move = (c == eau_pkg::EAU_C_MOVE_BYTE) ||
              (c == eau_pkg::EAU_C_MOVE_WORD);
  endfunction : is_move

  function automatic logic is_jump(input eau_pkg::eau_class_e c);
    is_jump = (c == eau_pkg::EAU_C_JUMP) ||
              (c == eau_pkg::EAU_C_JUMP_TO_SUBROUTINE);
  endfunction : is_jump

  function automatic logic is_rel(input eau_pkg::eau_class_e c);
    is_rel = (c == eau_pkg::EAU_C_BRANCH_COND) ||
             (c == eau_pkg::EAU_C_BRANCH_TO_SUBROUTINE);
  endfunction : is_rel

  function automatic logic is_bit(input eau_pkg::eau_class_e c);
    is_bit = (c == eau_pkg::EAU_C_BIT_REG_OK) ||
             (c == eau_pkg::EAU_C_BIT_IMM_ONLY);
  endfunction : is_bit

  function automatic logic mode_ok(input eau_pkg::eau_class_e c,
                                   input eau_pkg::eau_mode_e  m,
                                   input logic                st);
    case (m)
      eau_pkg::EAU_M_REG_DIRECT:   mode_ok = !is_rel(c) && !is_jump(c);
      eau_pkg::EAU_M_REG_INDIRECT: mode_ok = is_move(c) || is_bit(c) ||
                                             is_jump(c);
      eau_pkg::EAU_M_DISP16:       mode_ok = is_move(c);
      eau_pkg::EAU_M_POST_INC:     mode_ok = is_move(c) && !st;
      eau_pkg::EAU_M_PRE_DEC:      mode_ok = is_move(c) && st;
      eau_pkg::EAU_M_ABS8:         mode_ok = is_bit(c) ||
                                   (c == eau_pkg::EAU_C_MOVE_BYTE);
      eau_pkg::EAU_M_ABS16:        mode_ok = is_move(c) || is_jump(c);
      eau_pkg::EAU_M_IMM8:         mode_ok = (c == eau_pkg::EAU_C_ALU_IMM) ||
                                   (c == eau_pkg::EAU_C_MOVE_BYTE);
      eau_pkg::EAU_M_IMM16:        mode_ok =
                                   (c == eau_pkg::EAU_C_MOVE_WORD);
      eau_pkg::EAU_M_PC_REL:       mode_ok = is_rel(c);
      eau_pkg::EAU_M_MEM_IND:      mode_ok = is_jump(c);
      default:                     mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  // peripheral region takes the longer bus cycle
  function automatic logic [1:0] states_for(input logic [15:0] a);
    states_for = (a >= eau_pkg::EAU_PERIPH_BASE) ?
                 eau_pkg::EAU_STATES_PERIPH : eau_pkg::EAU_STATES_MEM;
  endfunction : states_for

  // --------------------------------------------------------------------
  // state and adder
  // --------------------------------------------------------------------
  localparam int EAU_LO = eau_pkg::EAU_BIT_LO;
  localparam int EAU_HI = eau_pkg::EAU_BIT_HI;

  eau_pkg::eau_state_s q;
  eau_pkg::eau_state_s d;
  logic [15:0]         add_a;
  logic [15:0]         add_b;
  logic [15:0]         add_sum;
  logic                word;
  logic                legal;
  logic                mem_op;
  logic                force_even;
  logic [15:0]         raw_ea;
  logic [15:0]         op_val;
  logic [15:0]         even_ea;

  assign word = (q.req.cls == eau_pkg::EAU_C_MOVE_WORD);

  always_comb begin
    add_a = q.req.reg_val;
    add_b = q.req.ext_word;
    case (q.req.mode)
      eau_pkg::EAU_M_POST_INC:
        add_b = word ? eau_pkg::EAU_STEP_WORD : eau_pkg::EAU_STEP_BYTE;
      eau_pkg::EAU_M_PRE_DEC:
        add_b = word ? eau_pkg::EAU_DEC_WORD : eau_pkg::EAU_DEC_BYTE;
      eau_pkg::EAU_M_PC_REL: begin
        // pc is the address after the branch, so reach is -126..+128
        add_a = q.req.pc;
        add_b = {{8{q.req.byte2[7]}}, q.req.byte2};
      end
      default: begin
      end
    endcase
  end

  eau_add16 u_add (
    .a_i   (add_a),
    .b_i   (add_b),
    .sum_o (add_sum)
  );

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  always_comb begin
    legal  = mode_ok(q.req.cls, q.req.mode, q.req.store) &&
             !(q.req.bit_from_reg &&
               q.req.cls == eau_pkg::EAU_C_BIT_IMM_ONLY);
    raw_ea = q.req.reg_val;
    op_val = q.req.reg_val;
    mem_op = 1'b1;
    case (q.req.mode)
      eau_pkg::EAU_M_REG_DIRECT: mem_op = 1'b0;
      eau_pkg::EAU_M_DISP16:     raw_ea = add_sum;
      eau_pkg::EAU_M_PRE_DEC:    raw_ea = add_sum;
      eau_pkg::EAU_M_PC_REL:     raw_ea = add_sum;
      eau_pkg::EAU_M_ABS8:
        raw_ea = {eau_pkg::EAU_ABS8_PAGE, q.req.byte2};
      eau_pkg::EAU_M_ABS16:      raw_ea = q.req.ext_word;
      eau_pkg::EAU_M_IMM8: begin
        mem_op = 1'b0;
        op_val = {8'h00, q.req.byte2};
      end
      eau_pkg::EAU_M_IMM16: begin
        mem_op = 1'b0;
        op_val = q.req.ext_word;
      end
      eau_pkg::EAU_M_MEM_IND:
        raw_ea = {eau_pkg::EAU_INDIRECT_PAGE, q.req.byte2};
      default: begin
      end
    endcase
    if (q.req.cls == eau_pkg::EAU_C_ADDRESS_ADD_SMALL ||
        q.req.cls == eau_pkg::EAU_C_ADDRESS_SUBTRACT_SMALL) begin
      op_val = q.req.small_two ? eau_pkg::EAU_STEP_WORD :
                                 eau_pkg::EAU_STEP_BYTE;
    end
    force_even = is_rel(q.req.cls) || is_jump(q.req.cls) ||
                 (word && mem_op);
    even_ea = force_even ? {raw_ea[15:1], 1'b0} : raw_ea;
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    unique case (q.fsm)
      eau_pkg::EAU_S_IDLE: begin
        if (req_valid_i) begin
          d.req = req_i;
          d.fsm = eau_pkg::EAU_S_CALC;
        end
      end
      eau_pkg::EAU_S_CALC: begin
        d.rsp.ea         = even_ea;
        d.rsp.operand    = op_val;
        d.rsp.in_memory  = mem_op;
        d.rsp.illegal    = !legal;
        d.rsp.lsb_forced = force_even && raw_ea[0];
        d.rsp.states     = states_for(even_ea);
        d.rsp.wb_val     = add_sum;
        d.rsp.wb_en      = legal &&
                           (q.req.mode == eau_pkg::EAU_M_POST_INC ||
                            q.req.mode == eau_pkg::EAU_M_PRE_DEC);
        if (q.req.bit_from_reg) begin
          d.rsp.bit_num = q.req.bit_reg[2:0];
        end else if (q.req.bit_in_byte4) begin
          d.rsp.bit_num = q.req.ext_word[EAU_HI:EAU_LO];
        end else begin
          d.rsp.bit_num = q.req.byte2[EAU_HI:EAU_LO];
        end
        if (legal && q.req.mode == eau_pkg::EAU_M_MEM_IND) begin
          d.fsm      = eau_pkg::EAU_S_FETCH;
          d.bus_addr = even_ea;
          d.cnt      = 2'h0;
          d.nstates  = states_for(even_ea);
        end else begin
          d.fsm       = eau_pkg::EAU_S_IDLE;
          d.rsp_valid = 1'b1;
        end
      end
      eau_pkg::EAU_S_FETCH: begin
        // one state per rising edge of the operating clock
        d.cnt = q.cnt + 2'h1;
        if (q.cnt == q.nstates - 2'h1) begin
          d.rsp.ea         = {bus_rdata_i[15:1], 1'b0};
          d.rsp.lsb_forced = bus_rdata_i[0];
          d.rsp.states     = states_for({bus_rdata_i[15:1], 1'b0});
          d.fsm            = eau_pkg::EAU_S_IDLE;
          d.rsp_valid      = 1'b1;
        end
      end
      default: d.fsm = eau_pkg::EAU_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q     <= '0;
      q.fsm <= eau_pkg::EAU_S_IDLE;
    end else begin
      q <= d;
    end
  end

  assign req_ready_o = (q.fsm == eau_pkg::EAU_S_IDLE);
  assign rsp_valid_o = q.rsp_valid;
  assign rsp_o       = q.rsp;
  assign bus_req_o   = (q.fsm == eau_pkg::EAU_S_FETCH);
  assign bus_word_o  = bus_req_o;
  assign bus_addr_o  = q.bus_addr;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  logic ok_q;
  assign ok_q = q.rsp_valid && !q.rsp.illegal;

  disp_sum_a: assert property (
    ok_q && q.req.mode == eau_pkg::EAU_M_DISP16 |->
    q.rsp.ea[15:1] == 15'((q.req.reg_val + q.req.ext_word) >> 1))
    else $error("displacement address wrong");

  post_inc_a: assert property (
    ok_q && q.req.mode == eau_pkg::EAU_M_POST_INC |->
    q.rsp.wb_en && q.rsp.ea[15:1] == q.req.reg_val[15:1] &&
    q.rsp.wb_val == q.req.reg_val + (word ? eau_pkg::EAU_STEP_WORD :
                                            eau_pkg::EAU_STEP_BYTE))
    else $error("post increment wrong");

  pre_dec_a: assert property (
    ok_q && q.req.mode == eau_pkg::EAU_M_PRE_DEC |->
    q.rsp.wb_en && q.rsp.ea[15:1] == q.rsp.wb_val[15:1] &&
    q.rsp.wb_val == q.req.reg_val - (word ? eau_pkg::EAU_STEP_WORD :
                                            eau_pkg::EAU_STEP_BYTE))
    else $error("pre decrement wrong");

  abs8_page_a: assert property (
    ok_q && q.req.mode == eau_pkg::EAU_M_ABS8 |->
    q.rsp.ea == {eau_pkg::EAU_ABS8_PAGE, q.req.byte2})
    else $error("short absolute page wrong");

  pc_rel_a: assert property (
    ok_q && q.req.mode == eau_pkg::EAU_M_PC_REL |->
    q.rsp.ea[15:1] == 15'((q.req.pc +
                           {{8{q.req.byte2[7]}}, q.req.byte2}) >> 1))
    else $error("relative target wrong");

  ind_fetch_a: assert property (
    $rose(bus_req_o) |-> bus_word_o && !bus_addr_o[0] &&
    bus_addr_o[15:8] == eau_pkg::EAU_INDIRECT_PAGE)
    else $error("indirect fetch address wrong");

  bus_len_a: assert property (
    $rose(bus_req_o) && bus_addr_o < eau_pkg::EAU_PERIPH_BASE |->
    bus_req_o ##1 bus_req_o ##1 (!bus_req_o && rsp_valid_o))
    else $error("memory bus cycle not two states");

  word_even_a: assert property (
    ok_q && (word && q.rsp.in_memory || is_rel(q.req.cls) ||
             is_jump(q.req.cls)) |-> !q.rsp.ea[0])
    else $error("odd word address issued");

  xfer_modes_a: assert property (
    q.rsp_valid && is_move(q.req.cls) &&
    (q.req.mode == eau_pkg::EAU_M_PC_REL ||
     q.req.mode == eau_pkg::EAU_M_MEM_IND) |-> q.rsp.illegal)
    else $error("transfer mode not refused");

  imm16_a: assert property (
    q.rsp_valid && q.req.mode == eau_pkg::EAU_M_IMM16 |->
    q.rsp.illegal == !word)
    else $error("long immediate legality wrong");

endmodule : eau_core

// ---- eau_pkg.sv ----
// eau_pkg.sv: types and constants shared by the effective address unit
// assumes a 16-bit address space and one operating clock for the cpu
package eau_pkg;

  // --------------------------------------------------------------------
  // addressing modes and instruction classes
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    EAU_M_REG_DIRECT   = 4'h0,
    EAU_M_REG_INDIRECT = 4'h1,
    EAU_M_DISP16       = 4'h2,
    EAU_M_POST_INC     = 4'h3,
    EAU_M_PRE_DEC      = 4'h4,
    EAU_M_ABS8         = 4'h5,
    EAU_M_ABS16        = 4'h6,
    EAU_M_IMM8         = 4'h7,
    EAU_M_IMM16        = 4'h8,
    EAU_M_PC_REL       = 4'h9,
    EAU_M_MEM_IND      = 4'ha
  } eau_mode_e;

  typedef enum logic [3:0] {
    EAU_C_MOVE_BYTE              = 4'h0,
    EAU_C_MOVE_WORD              = 4'h1,
    EAU_C_JUMP                   = 4'h2,
    EAU_C_JUMP_TO_SUBROUTINE     = 4'h3,
    EAU_C_BRANCH_COND            = 4'h4,
    EAU_C_BRANCH_TO_SUBROUTINE   = 4'h5,
    EAU_C_ALU_IMM                = 4'h6,
    EAU_C_ALU_REG                = 4'h7,
    EAU_C_ADDRESS_ADD_SMALL      = 4'h8,
    EAU_C_ADDRESS_SUBTRACT_SMALL = 4'h9,
    EAU_C_BIT_REG_OK             = 4'ha,
    EAU_C_BIT_IMM_ONLY           = 4'hb
  } eau_class_e;

  typedef enum logic [2:0] {
    EAU_S_IDLE  = 3'h1,
    EAU_S_CALC  = 3'h2,
    EAU_S_FETCH = 3'h4
  } eau_fsm_e;

  // --------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------
  localparam logic [7:0]  EAU_ABS8_PAGE     = 8'hff;
  localparam logic [7:0]  EAU_INDIRECT_PAGE = 8'h00;
  localparam logic [15:0] EAU_STEP_BYTE     = 16'h0001;
  localparam logic [15:0] EAU_STEP_WORD     = 16'h0002;
  localparam logic [15:0] EAU_DEC_BYTE      = 16'hffff;
  localparam logic [15:0] EAU_DEC_WORD      = 16'hfffe;
  localparam logic [15:0] EAU_PERIPH_BASE   = 16'hff80;
  localparam logic [1:0]  EAU_STATES_MEM    = 2'h2;
  localparam logic [1:0]  EAU_STATES_PERIPH = 2'h3;
  localparam int          EAU_BIT_LO        = 4;
  localparam int          EAU_BIT_HI        = 6;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    eau_class_e  cls;
    eau_mode_e   mode;
    logic        store;
    logic        small_two;
    logic        bit_from_reg;
    logic        bit_in_byte4;
    logic [15:0] reg_val;
    logic [7:0]  bit_reg;
    logic [7:0]  byte2;
    logic [15:0] ext_word;
    logic [15:0] pc;
  } eau_req_s;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] operand;
    logic        in_memory;
    logic        wb_en;
    logic [15:0] wb_val;
    logic [2:0]  bit_num;
    logic        illegal;
    logic        lsb_forced;
    logic [1:0]  states;
  } eau_rsp_s;

  typedef struct packed {
    eau_fsm_e    fsm;
    eau_req_s    req;
    eau_rsp_s    rsp;
    logic        rsp_valid;
    logic [15:0] bus_addr;
    logic [1:0]  cnt;
    logic [1:0]  nstates;
  } eau_state_s;

endpackage : eau_pkg

// ---- tb_effective_address_unit.sv ----
// tb_effective_address_unit.sv: self-checking bench for eau_core
// assumes eau_pkg and eau_core are compiled first; 10 MHz clock
`timescale 1ns/1ns
module tb_effective_address_unit;
  logic              clk_sys_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              req_valid_i = 1'b0;
  eau_pkg::eau_req_s req_i = '0;
  logic              req_ready_o;
  logic              rsp_valid_o;
  eau_pkg::eau_rsp_s rsp_o;
  logic              bus_req_o;
  logic              bus_word_o;
  logic [15:0]       bus_addr_o;
  logic [15:0]       bus_rdata_i;
  int                err_total = 0;
  int                checks = 0;
  int                seed = 32'hdd3bb31c;

  always #50 clk_sys_i = ~clk_sys_i;

  eau_core dut_u (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .req_ready_o (req_ready_o),
    .rsp_valid_o (rsp_valid_o),
    .rsp_o       (rsp_o),
    .bus_req_o   (bus_req_o),
    .bus_word_o  (bus_word_o),
    .bus_addr_o  (bus_addr_o),
    .bus_rdata_i (bus_rdata_i)
  );

  eau_bus_mem mem_u (
    .clk_sys_i  (clk_sys_i),
    .bus_req_i  (bus_req_o),
    .bus_addr_i (bus_addr_o),
    .rdata_o    (bus_rdata_i)
  );

  // ------------------------------------------------------------------
  // checking and reference
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  function automatic void ref_calc(input eau_pkg::eau_req_s r,
      output logic ok, output logic eav, output logic [15:0] ea,
      output logic opv, output logic [15:0] op,
      output logic wbe, output logic [15:0] wbv, output logic lsb);
    logic mv, jp, br, bt, wd;
    logic [15:0] st;
    mv = r.cls inside {eau_pkg::EAU_C_MOVE_BYTE, eau_pkg::EAU_C_MOVE_WORD};
    jp = r.cls inside {eau_pkg::EAU_C_JUMP,
                       eau_pkg::EAU_C_JUMP_TO_SUBROUTINE};
    br = r.cls inside {eau_pkg::EAU_C_BRANCH_COND,
                       eau_pkg::EAU_C_BRANCH_TO_SUBROUTINE};
    bt = r.cls inside {eau_pkg::EAU_C_BIT_REG_OK,
                       eau_pkg::EAU_C_BIT_IMM_ONLY};
    wd = r.cls == eau_pkg::EAU_C_MOVE_WORD;
    st = wd ? 16'h0002 : 16'h0001;
    ok = 1'b0; eav = 1'b1; ea = 16'h0000; opv = 1'b0;
    op = 16'h0000; wbe = 1'b0; wbv = 16'h0000;
    lsb = 1'b0;
    case (r.mode)
      eau_pkg::EAU_M_REG_DIRECT: begin
        ok = !(jp || br); eav = 1'b0;
        opv = 1'b1;
        op = r.reg_val;
        if (r.cls inside {eau_pkg::EAU_C_ADDRESS_ADD_SMALL,
                          eau_pkg::EAU_C_ADDRESS_SUBTRACT_SMALL}) begin
          op = r.small_two ? 16'h0002 : 16'h0001;
        end
      end
      eau_pkg::EAU_M_REG_INDIRECT: begin ok = mv || bt || jp; ea = r.reg_val; end
      eau_pkg::EAU_M_DISP16: begin ok = mv; ea = r.reg_val + r.ext_word; end
      eau_pkg::EAU_M_POST_INC: begin
        ok = mv && !r.store; ea = r.reg_val; wbe = 1'b1;
        wbv = r.reg_val + st;
      end
      eau_pkg::EAU_M_PRE_DEC: begin
        ok = mv && r.store; ea = r.reg_val - st; wbe = 1'b1; wbv = ea;
      end
      eau_pkg::EAU_M_ABS8: begin
        ok = (r.cls == eau_pkg::EAU_C_MOVE_BYTE) || bt; ea = {8'hff, r.byte2};
      end
      eau_pkg::EAU_M_ABS16: begin ok = mv || jp; ea = r.ext_word; end
      eau_pkg::EAU_M_IMM8: begin
        ok = r.cls inside {eau_pkg::EAU_C_MOVE_BYTE, eau_pkg::EAU_C_ALU_IMM};
        eav = 1'b0; opv = 1'b1; op = {8'h00, r.byte2};
      end
      eau_pkg::EAU_M_IMM16: begin
        ok = wd; eav = 1'b0; opv = 1'b1; op = r.ext_word;
      end
      eau_pkg::EAU_M_PC_REL: begin
        ok = br; ea = r.pc + {{8{r.byte2[7]}}, r.byte2};
      end
      eau_pkg::EAU_M_MEM_IND: begin
        ok = jp;
        // table word is a fixed function of its even address
        ea = {{r.byte2[7:1], 1'b0} ^ 8'ha5, r.byte2[7:1], 1'b1};
      end
      default: ok = 1'b0;
    endcase
    // immediate-only bit ops refuse a register bit source
    if (r.bit_from_reg && r.cls == eau_pkg::EAU_C_BIT_IMM_ONLY) begin
      ok = 1'b0;
    end
    if (wd || jp || br) begin
      lsb = ea[0];
      ea[0] = 1'b0;
    end
  endfunction : ref_calc

  // ------------------------------------------------------------------
  // one request, end to end
  // ------------------------------------------------------------------
  task automatic run(input eau_pkg::eau_req_s r);
    logic ok, eav, opv, wbe, ind, lsb;
    logic [15:0] ea, op, wbv, lat, nb;
    ref_calc(r, ok, eav, ea, opv, op, wbe, wbv, lsb);
    req_i = r;
    req_valid_i = 1'b1;
    lat = 16'h0000;
    while (req_ready_o !== 1'b1 && lat < 16'h0014) begin
      @(posedge clk_sys_i); #10; lat++;
    end
    @(posedge clk_sys_i); #10;
    req_valid_i = 1'b0;
    lat = 16'h0001;
    nb = 16'h0000;
    while (rsp_valid_o !== 1'b1 && lat < 16'h0014) begin
      if (bus_req_o === 1'b1) begin
        nb++;
        check("bus_addr", bus_addr_o, {8'h00, r.byte2[7:1], 1'b0});
        check("bus_word", {15'h0000, bus_word_o}, 16'h0001);
      end
      @(posedge clk_sys_i); #10; lat++;
    end
    ind = ok && r.mode == eau_pkg::EAU_M_MEM_IND;
    check("latency", lat, ind ? 16'h0004 : 16'h0002);
    check("bus_states", nb, ind ? 16'h0002 : 16'h0000);
    check("illegal", {15'h0000, rsp_o.illegal}, {15'h0000, !ok});
    check("wb_en", {15'h0000, rsp_o.wb_en}, {15'h0000, ok && wbe});
    if (ok && eav) check("ea", rsp_o.ea, ea);
    if (ok) check("in_memory", {15'h0000, rsp_o.in_memory},
                  {15'h0000, eav});
    if (ok && eav) begin
      check("states", {14'h0000, rsp_o.states},
            {14'h0000, (ea >= eau_pkg::EAU_PERIPH_BASE) ?
             eau_pkg::EAU_STATES_PERIPH : eau_pkg::EAU_STATES_MEM});
      check("lsb_forced", {15'h0000, rsp_o.lsb_forced},
            {15'h0000, lsb});
    end
    if (ok && opv) check("operand", rsp_o.operand, op);
    if (ok && wbe) check("wb_val", rsp_o.wb_val, wbv);
    if (ok && r.cls inside {eau_pkg::EAU_C_BIT_REG_OK,
                            eau_pkg::EAU_C_BIT_IMM_ONLY}) begin
      check("bit_num", {13'h0000, rsp_o.bit_num},
            {13'h0000, (r.bit_from_reg && r.cls == eau_pkg::EAU_C_BIT_REG_OK)
             ? r.bit_reg[2:0] : r.bit_in_byte4 ? r.ext_word[6:4]
             : r.byte2[6:4]});
    end
    @(posedge clk_sys_i); #10;
    check("rsp_pulse", {15'h0000, rsp_valid_o}, 16'h0000);
  endtask : run

  task automatic rnd(input int c, input int m);
    eau_pkg::eau_req_s r;
    logic [95:0] rw;
    rw = {$random(seed), $random(seed), $random(seed)};
    r = rw[75:0];
    r.cls = eau_pkg::eau_class_e'(4'(c));
    r.mode = eau_pkg::eau_mode_e'(4'(m));
    run(r);
  endtask : rnd

  task automatic corner(input int c, input int m, input logic st,
                        input logic [15:0] rv, input logic [7:0] b2,
                        input logic [15:0] ext, input logic [15:0] pc);
    eau_pkg::eau_req_s r;
    r = '0;
    r.cls = eau_pkg::eau_class_e'(4'(c));
    r.mode = eau_pkg::eau_mode_e'(4'(m));
    r.store = st; r.reg_val = rv; r.byte2 = b2;
    r.ext_word = ext; r.pc = pc;
    run(r);
  endtask : corner

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #10;
    arst_n_i = 1'b1;
    corner(1, 3, 1'b0, 16'hfffe, 8'h00, 16'h0000, 16'h0000);
    corner(0, 4, 1'b1, 16'h0000, 8'h00, 16'h0000, 16'h0000);
    corner(1, 4, 1'b1, 16'h1234, 8'h00, 16'h0000, 16'h0000);
    corner(4, 9, 1'b0, 16'h0000, 8'h80, 16'h0000, 16'h0002);
    corner(5, 9, 1'b0, 16'h0000, 8'h7f, 16'h0000, 16'hfff0);
    corner(1, 2, 1'b0, 16'hff00, 8'h00, 16'h0201, 16'h0000);
    corner(3, 10, 1'b0, 16'h0000, 8'hff, 16'h0000, 16'h0000);
    corner(0, 5, 1'b0, 16'h0000, 8'h00, 16'h0000, 16'h0000);
    corner(2, 6, 1'b0, 16'h0000, 8'h00, 16'h4567, 16'h0000);
    $display("corner tests done");
    // reset again in mid-run; unit must come back idle and cleared
    arst_n_i = 1'b0;
    @(posedge clk_sys_i); #10;
    check("rst_ready", {15'h0000, req_ready_o}, 16'h0001);
    check("rst_ea", rsp_o.ea, 16'h0000);
    arst_n_i = 1'b1;
    for (int c = 0; c < 12; c++) begin
      for (int m = 0; m < 11; m++) begin
        rnd(c, m);
      end
    end
    $display("mode sweep done");
    for (int i = 0; i < 200; i++) begin
      rnd($unsigned($random(seed)) % 12, $unsigned($random(seed)) % 11);
    end
    $display("random tests done");
    stop_test();
  end

  initial begin
    #2_000_000;
    err_total++;
    stop_test();
  end
endmodule : tb_effective_address_unit
